// file: dv/load_model.sv
`timescale 1ns/100ps
module load_model (
    output reg link_clk,
    input wire [10:0] hs_drv,
    input wire [5:0] ls_drv,
    input wire [10:0] ol_mask,
    input wire [10:0] oc_mask,
    output wire [10:0] undercur,
    output wire [10:0] overcur
);
    // timebase runs free, phase offset from mclk on purpose
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end
    // an output with neither driver on carries no current, so it reads as under-current
    assign undercur = ol_mask | ~(hs_drv | {5'h00, ls_drv});
    assign overcur = oc_mask & hs_drv;
endmodule

// file: dv/opc_assertions.sv
`timescale 1ns/100ps
module opc_checker #(
    parameter NOUT = 11,
    parameter NHB = 6,
    parameter [19:0] TW_FILT_CYC = 20,
    parameter [19:0] OC_FILT_CYC = 10
) (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pslverr,
    input wire vcc_low,
    input wire vcc_high,
    input wire temp_sd,
    input wire [NOUT-1:0] overcur,
    input wire [NOUT-1:0] hs_drv,
    input wire [NHB-1:0] ls_drv,
    input wire [NHB-1:0] fast_off_hs,
    input wire drv_oe,
    input wire gate_rl,
    input wire [3:0] current_image_sel,
    input wire current_image_pin_oe
);
    localparam int XC = 500;
    localparam int BLANK = 4000;
    logic [12:0] off_cnt, on_cnt, sd_cnt;
    logic [7:0] oc_cnt;
    wire sel_on = (current_image_sel < 4'hB) && hs_drv[current_image_sel];
    // off_cnt starts saturated: no dead time is owed straight after reset
    // sd_cnt counts from the last read-and-clear, saturated when none came yet
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt <= 13'h1FFF;
            on_cnt <= 13'h0;
            sd_cnt <= 13'h1FFF;
            oc_cnt <= 8'h0;
        end else begin
            off_cnt <= hs_drv[0] ? 13'h0 : off_cnt + {12'h0, ~&off_cnt};
            on_cnt <= sel_on ? on_cnt + {12'h0, ~&on_cnt} : 13'h0;
            sd_cnt <= (psel && penable && paddr[6]) ? 13'h0 : sd_cnt + {12'h0, ~&sd_cnt};
            oc_cnt <= (overcur[8] && hs_drv[8]) ? oc_cnt + {7'h0, ~&oc_cnt} : 8'h0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence sel_off_s;
        !sel_on [*3];
    endsequence
    sequence ls_on_s;
        $rose(ls_drv[0]);
    endsequence
    a_apb_error: assert property (setup_s |=> pslverr == ((($past(paddr) & 8'hBF) > 8'h24) || (($past(paddr) & 8'h03) != 8'h0)))
        else $error("pslverr does not follow the address decode");
    a_no_shoot: assert property ((hs_drv[NHB-1:0] & ls_drv) == '0)
        else $error("both drivers of a half bridge on");
    a_dead_time: assert property (ls_on_s |-> off_cnt >= XC - 2)
        else $error("low side on before the dead time ran out");
    a_fast_first: assert property (ls_on_s |-> $past(fast_off_hs[0]))
        else $error("low side on without fast turn-off of high side");
    a_low_hiz: assert property (vcc_low [*4] |-> !drv_oe)
        else $error("outputs enabled with supply low");
    a_high_off: assert property (vcc_high [*4] |-> hs_drv == '0 && ls_drv == '0)
        else $error("drivers on with supply above reset level");
    a_tsd_gates: assert property (gate_rl |-> hs_drv == '0 && ls_drv == '0)
        else $error("drivers on during thermal shutdown");
    a_tsd_twice: assert property ($rose(gate_rl) && temp_sd |-> sd_cnt >= 2 * TW_FILT_CYC)
        else $error("shutdown sooner than two filter times");
    a_oc_bound: assert property (oc_cnt <= OC_FILT_CYC + 4)
        else $error("driver kept on through filtered overcurrent");
    a_blank_min: assert property ($rose(current_image_pin_oe) |-> on_cnt >= BLANK - 2)
        else $error("monitor enabled before blanking time");
    a_mon_off: assert property (sel_off_s |-> !current_image_pin_oe)
        else $error("monitor enabled while selected output off");
endmodule

// file: dv/tb.sv
`timescale 1ns/100ps
`include "opc_consts.vh"
module tb;
    localparam [19:0] TW = 20'd20;
    localparam [19:0] OLF = 20'd20;
    localparam [19:0] OCF = 20'd10;
    localparam [19:0] REC12 = 20'd40;
    localparam [19:0] REC25 = 20'd20;
    localparam [10:0] STEPS = 11'd4;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic vcc_low = 1'b0, vcc_high = 1'b0, temp_warn = 1'b0, temp_sd = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [10:0] ol_mask = 11'h0, oc_mask = 11'h0;
    wire [31:0] prdata;
    wire pready, pslverr, link_clk, drv_oe, gate_rl, current_image_pin_oe;
    wire [10:0] undercur, overcur, hs_drv;
    wire [5:0] ls_drv, fast_off_hs, fast_off_ls;
    wire [3:0] current_image_sel;
    int fail_count = 0, total_checks = 0, cycles = 0, hi, per, n, step;
    output_protection_pwm_control #(.TW_FILT_CYC(TW), .OL_FILT_CYC(OLF), .OC_FILT_CYC(OCF),
        .REC12_CYC(REC12), .REC25_CYC(REC25), .PWM_STEP_EDGES(STEPS)) dut (.mclk(mclk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vcc_low(vcc_low), .vcc_high(vcc_high), .temp_warn(temp_warn),
        .temp_sd(temp_sd), .link_clk(link_clk), .undercur(undercur), .overcur(overcur), .hs_drv(hs_drv),
        .ls_drv(ls_drv), .fast_off_hs(fast_off_hs), .fast_off_ls(fast_off_ls), .drv_oe(drv_oe),
        .gate_rl(gate_rl), .current_image_sel(current_image_sel), .current_image_pin_oe(current_image_pin_oe));
    load_model load (.link_clk(link_clk), .hs_drv(hs_drv), .ls_drv(ls_drv), .ol_mask(ol_mask), .oc_mask(oc_mask),
        .undercur(undercur), .overcur(overcur));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 100000) begin
            fail_count++;
            stop_test;
        end
    end
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task check_rng(input string name, input int lo, input int up, input int got);
        total_checks++;
        if (got < lo || got > up) begin
            fail_count++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, up, got);
        end
    endtask
    // holds the request until pready is sampled high, no fixed latency assumed
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask
    task cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task wait_hs(input int i, input logic v);
        n = 0;
        while (hs_drv[i] !== v && n < 20000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task pulse(input int i);
        wait_hs(i, 1'b0);
        wait_hs(i, 1'b1);
        wait_hs(i, 1'b0);
        hi = n;
        wait_hs(i, 1'b1);
        per = hi + n;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rdchk("gstat reset", `GSTAT_OFS, 32'h0);
        rdchk("out_on reset", `OUT_ON_OFS, 32'h0);
        check("drv_oe", 32'h1, {31'h0, drv_oe});
        apb(1'b0, 8'h28, 32'h0);
        check("unmapped", 32'h1, {31'h0, err});
        wr(`HB_SIDE_OFS, 32'h1);
        wr(`OUT_ON_OFS, 32'h1);
        cyc(600);
        check("hs0 on", 32'h1, {31'h0, hs_drv[0]});
        wr(`HB_SIDE_OFS, 32'h0);
        cyc(400);
        check("ls0 dead", 32'h0, {31'h0, ls_drv[0]});
        cyc(200);
        check("ls0 on", 32'h1, {31'h0, ls_drv[0]});
        wr(`OUT_ON_OFS, 32'h0);
        cyc(510);
        check("ls0 fast off", 32'h1, {31'h0, fast_off_ls[0]});
        ol_mask <= 11'h0C0;
        repeat (2) begin
            wr(`OUT_ON_OFS, 32'h40);
            cyc(8);
            wr(`OUT_ON_OFS, 32'h0);
        end
        wr(`OUT_ON_OFS, 32'h80);
        cyc(40);
        wr(`OUT_ON_OFS, 32'h0);
        rdchk("open load", `OL_STAT_OFS, 32'h80);
        ol_mask <= 11'h0;
        wr(`OL_STAT_OFS, 32'h80);
        rdchk("open load w1c", `OL_STAT_OFS, 32'h0);
        oc_mask <= 11'h100;
        wr(`OUT_ON_OFS, 32'h100);
        cyc(30);
        check("oc off", 32'h0, {31'h0, hs_drv[8]});
        rdchk("oc flag", `OC_STAT_OFS, 32'h100);
        oc_mask <= 11'h0;
        cyc(20);
        check("oc held", 32'h0, {31'h0, hs_drv[8]});
        wr(`OC_STAT_OFS, 32'h100);
        cyc(10);
        check("oc reenable", 32'h1, {31'h0, hs_drv[8]});
        wr(`OC_REC_OFS, 32'h100);
        for (int k = 0; k < 2; k++) begin
            wr(`CFG_OFS, k << `CFG_RDUTY_BIT);
            oc_mask <= 11'h100;
            wait_hs(8, 1'b0);
            wait_hs(8, 1'b1);
            check_rng("recovery", (k ? REC25 : REC12) - 2, (k ? REC25 : REC12) + 6, n);
            oc_mask <= 11'h0;
        end
        wr(`OC_REC_OFS, 32'h0);
        wr(`OC_STAT_OFS, 32'h100);
        temp_warn <= 1'b1;
        cyc(40);
        rdchk("warn", `GSTAT_OFS, 32'h1);
        check("warn keeps out", 32'h1, {31'h0, hs_drv[8]});
        temp_sd <= 1'b1;
        n = 0;
        while (gate_rl !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        check("tsd off", 32'h0, {31'h0, hs_drv[8]});
        rdchk("tsd latched", `GSTAT_OFS, 32'h3);
        apb(1'b0, `OUT_ON_OFS | 8'h40, 32'h0);
        rdchk("tsd cleared", `GSTAT_OFS, 32'h0);
        cyc(2);
        check("tsd reenable", 32'h1, {31'h0, hs_drv[8]});
        n = 0;
        while (gate_rl !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        check_rng("tsd again", 2 * TW - 8, 199, n);
        temp_warn <= 1'b0;
        temp_sd <= 1'b0;
        apb(1'b0, `GSTAT_OFS | 8'h40, 32'h0);
        wr(`PWM_MAP_OFS, 32'h3 << 18);
        wr(`DUTY_OFS, 32'h40 << 24);
        wr(`PWM_EN_OFS, 32'h200);
        wr(`OUT_ON_OFS, 32'h200);
        for (int f = 0; f < 2; f++) begin
            wr(`CFG_OFS, f);
            step = 48 >> f;
            pulse(9);
            check_rng("pwm high", 64 * step - 16, 64 * step + 16, hi);
            check_rng("pwm period", 128 * step - 16, 128 * step + 16, per);
        end
        wr(`DUTY_OFS, 32'h7F << 24);
        pulse(9);
        check_rng("pwm max low", step - 16, step + 16, per - hi);
        wr(`OUT_ON_OFS, 32'h0);
        cyc(10);
        check("pwm and", 32'h0, {31'h0, hs_drv[9]});
        wr(`CFG_OFS, 32'h7 << `CFG_MSEL_LSB);
        cyc(3);
        check("mon sel", 32'h7, {28'h0, current_image_sel});
        wr(`OUT_ON_OFS, 32'h80);
        n = 0;
        while (current_image_pin_oe !== 1'b1 && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        check_rng("blanking", 3990, 4010, n);
        wr(`OUT_ON_OFS, 32'h0);
        cyc(5);
        check("mon hiz", 32'h0, {31'h0, current_image_pin_oe});
        ol_mask <= 11'h80;
        wr(`OUT_ON_OFS, 32'h80);
        cyc(40);
        vcc_low <= 1'b1;
        ol_mask <= 11'h0;
        cyc(6);
        check("low hiz", 32'h0, {31'h0, drv_oe});
        vcc_low <= 1'b0;
        cyc(6);
        rdchk("low clears", `OL_STAT_OFS, 32'h0);
        vcc_high <= 1'b1;
        cyc(6);
        check("high off", 32'h0, {31'h0, hs_drv[7]});
        vcc_high <= 1'b0;
        cyc(6);
        rdchk("high clears", `OUT_ON_OFS, 32'h0);
        stop_test;
    end
endmodule
bind output_protection_pwm_control opc_checker #(.NOUT(NOUT), .NHB(NHB), .TW_FILT_CYC(TW_FILT_CYC),
    .OC_FILT_CYC(OC_FILT_CYC)) chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .vcc_low(vcc_low), .vcc_high(vcc_high), .temp_sd(temp_sd),
    .overcur(overcur), .hs_drv(hs_drv), .ls_drv(ls_drv), .fast_off_hs(fast_off_hs), .drv_oe(drv_oe),
    .gate_rl(gate_rl), .current_image_sel(current_image_sel), .current_image_pin_oe(current_image_pin_oe));

// file: src/opc_consts.vh
`ifndef OPC_CONSTS_VH
`define OPC_CONSTS_VH

`define OUT_ON_OFS 8'h00
`define HB_SIDE_OFS 8'h04
`define PWM_EN_OFS 8'h08
`define OC_REC_OFS 8'h0C
`define CFG_OFS 8'h10
`define DUTY_OFS 8'h14
`define PWM_MAP_OFS 8'h18
`define GSTAT_OFS 8'h1C
`define OL_STAT_OFS 8'h20
`define OC_STAT_OFS 8'h24
`define RC_ALIAS_BIT 6

`define CFG_FREQ_BIT 0
`define CFG_RDUTY_BIT 1
`define CFG_MSEL_LSB 4
`define GSTAT_WARN_BIT 0
`define GSTAT_TSD_BIT 1
`define GSTAT_VLOW_BIT 2

`define MCLK_MHZ 250
`define T_XC_NS 2000
`define XC_CYC ((`T_XC_NS * `MCLK_MHZ + 999) / 1000)
`define T_BLANK_NS 16000
`define BLANK_CYC ((`T_BLANK_NS * `MCLK_MHZ + 999) / 1000)
`define T_TW_US 32
`define TW_FILT_CYC (`T_TW_US * `MCLK_MHZ)
`define T_OL_US 2000
`define OL_FILT_CYC (`T_OL_US * `MCLK_MHZ)
`define T_OC_US 10
`define OC_FILT_CYC (`T_OC_US * `MCLK_MHZ)
`define T_REC12_US 512
`define REC12_CYC (`T_REC12_US * `MCLK_MHZ)
`define T_REC25_US 256
`define REC25_CYC (`T_REC25_US * `MCLK_MHZ)
`define PWM_STEP_EDGES 1333

`endif

// file: src/output_protection_pwm_control.v
`timescale 1ns/100ps
`include "opc_consts.vh"

module output_protection_pwm_control #(
    parameter NOUT = 11,
    parameter NHB = 6,
    parameter [19:0] TW_FILT_CYC = `TW_FILT_CYC,
    parameter [19:0] OL_FILT_CYC = `OL_FILT_CYC,
    parameter [19:0] OC_FILT_CYC = `OC_FILT_CYC,
    parameter [19:0] REC12_CYC = `REC12_CYC,
    parameter [19:0] REC25_CYC = `REC25_CYC,
    parameter [10:0] PWM_STEP_EDGES = `PWM_STEP_EDGES
) (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire vcc_low,
    input wire vcc_high,
    input wire temp_warn,
    input wire temp_sd,
    input wire link_clk,
    input wire [NOUT-1:0] undercur,
    input wire [NOUT-1:0] overcur,
    output wire [NOUT-1:0] hs_drv,
    output wire [NHB-1:0] ls_drv,
    output wire [NHB-1:0] fast_off_hs,
    output wire [NHB-1:0] fast_off_ls,
    output reg drv_oe,
    output reg gate_rl,
    output reg [3:0] current_image_sel,
    output reg current_image_pin_oe
);
    localparam [19:0] XC_CYC = `XC_CYC;
    localparam [19:0] BLANK_CYC = `BLANK_CYC;
    localparam SW = 5 + 2 * NOUT;

    wire [SW-1:0] sync_out;
    wire vcc_low_s;
    wire vcc_high_s;
    wire warn_s;
    wire sd_s;
    wire lk_s;
    wire [NOUT-1:0] uc_s;
    wire [NOUT-1:0] ocr_s;

    sync2 #(.WIDTH(SW)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d({vcc_low, vcc_high, temp_warn, temp_sd, link_clk, undercur, overcur}),
        .q(sync_out)
    );
    assign {vcc_low_s, vcc_high_s, warn_s, sd_s, lk_s, uc_s, ocr_s} = sync_out;

    wire clr_all = vcc_high_s;
    wire clr_stat = vcc_low_s | vcc_high_s;

    // control registers
    reg [NOUT-1:0] out_on_q;
    reg [NHB-1:0] hb_side_q;
    reg [NOUT-1:0] pwm_en_q;
    reg [NOUT-1:0] oc_rec_q;
    reg freq_q;
    reg rduty_q;
    reg [3:0] msel_q;
    reg [27:0] duty_q;
    reg [2*NOUT-1:0] pwm_map_q;

    wire [7:0] ofs = {paddr[7], 1'b0, paddr[5:0]};
    wire rc_alias = paddr[`RC_ALIAS_BIT];
    wire mapped = (ofs[1:0] == 2'b00) && (ofs <= `OC_STAT_OFS);
    wire acc = psel & penable;
    wire wr_en = acc & pwrite & mapped;
    wire rc_rd = acc & ~pwrite & mapped & rc_alias;
    assign pready = 1'b1;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_on_q <= {NOUT{1'b0}};
            hb_side_q <= {NHB{1'b0}};
            pwm_en_q <= {NOUT{1'b0}};
            oc_rec_q <= {NOUT{1'b0}};
            freq_q <= 1'b0;
            rduty_q <= 1'b0;
            msel_q <= 4'h0;
            duty_q <= 28'h0000000;
            pwm_map_q <= {2*NOUT{1'b0}};
        end else if (clr_all) begin
            out_on_q <= {NOUT{1'b0}};
            hb_side_q <= {NHB{1'b0}};
            pwm_en_q <= {NOUT{1'b0}};
            oc_rec_q <= {NOUT{1'b0}};
            freq_q <= 1'b0;
            rduty_q <= 1'b0;
            msel_q <= 4'h0;
            duty_q <= 28'h0000000;
            pwm_map_q <= {2*NOUT{1'b0}};
        end else if (wr_en) begin
            case (ofs)
                `OUT_ON_OFS: out_on_q <= pwdata[NOUT-1:0];
                `HB_SIDE_OFS: hb_side_q <= pwdata[NHB-1:0];
                `PWM_EN_OFS: pwm_en_q <= pwdata[NOUT-1:0];
                `OC_REC_OFS: oc_rec_q <= pwdata[NOUT-1:0];
                `CFG_OFS: begin
                    freq_q <= pwdata[`CFG_FREQ_BIT];
                    rduty_q <= pwdata[`CFG_RDUTY_BIT];
                    msel_q <= pwdata[`CFG_MSEL_LSB+3:`CFG_MSEL_LSB];
                end
                `DUTY_OFS: duty_q <= {pwdata[30:24], pwdata[22:16], pwdata[14:8], pwdata[6:0]};
                `PWM_MAP_OFS: pwm_map_q <= pwdata[2*NOUT-1:0];
                default: ;
            endcase
        end
    end

    // thermal supervision
    reg [19:0] tw_cnt_q;
    reg [19:0] ts_cnt_q;
    reg warn_q;
    reg tsd_q;
    wire warn_hit = warn_s && (tw_cnt_q == TW_FILT_CYC - 20'h00001);
    // shutdown only qualifies once warning is latched, so two filter times after a clear
    wire tsd_hit = sd_s && warn_q && (ts_cnt_q == TW_FILT_CYC - 20'h00001);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tw_cnt_q <= 20'h00000;
            ts_cnt_q <= 20'h00000;
            warn_q <= 1'b0;
            tsd_q <= 1'b0;
        end else begin
            tw_cnt_q <= (warn_s && !warn_hit && !warn_q) ? tw_cnt_q + 20'h00001 : 20'h00000;
            ts_cnt_q <= (sd_s && warn_q && !tsd_hit && !tsd_q) ? ts_cnt_q + 20'h00001 : 20'h00000;
            if (clr_stat) begin
                warn_q <= 1'b0;
                tsd_q <= 1'b0;
            end else begin
                // set wins over the read-and-clear
                if (warn_hit)
                    warn_q <= 1'b1;
                else if (rc_rd)
                    warn_q <= 1'b0;
                if (tsd_hit)
                    tsd_q <= 1'b1;
                else if (rc_rd)
                    tsd_q <= 1'b0;
            end
        end
    end

    // pwm timebase from the sampled link clock
    reg lk_d_q;
    reg [10:0] pre_q;
    wire lk_edge = lk_s & ~lk_d_q;
    wire [10:0] step_lim = freq_q ? {1'b0, PWM_STEP_EDGES[10:1]} : PWM_STEP_EDGES;
    wire step = lk_edge && (pre_q >= step_lim - 11'h001);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lk_d_q <= 1'b0;
            pre_q <= 11'h000;
        end else begin
            lk_d_q <= lk_s;
            if (lk_edge)
                pre_q <= step ? 11'h000 : pre_q + 11'h001;
        end
    end

    wire [3:0] pwm_wave;
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_pwm
            reg [6:0] cnt_q;
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n)
                    cnt_q <= 7'h00;
                else if (clr_all)
                    cnt_q <= 7'h00;
                else if (step)
                    cnt_q <= cnt_q + 7'h01;
            end
            // duty 127 gives 127 of 128 steps, never fully on
            assign pwm_wave[k] = cnt_q < duty_q[7*k+6:7*k];
        end
    endgenerate

    // per-output gating, diagnostics and recovery
    reg [NOUT-1:0] ol_q;
    reg [NOUT-1:0] oc_q;
    wire [NOUT-1:0] want_on;
    wire [NOUT-1:0] driving;
    wire [NOUT-1:0] ol_hit;
    wire [NOUT-1:0] oc_hit;
    wire [NOUT-1:0] rec_done;
    wire [19:0] rec_len = rduty_q ? REC25_CYC : REC12_CYC;
    genvar i;
    generate
        for (i = 0; i < NOUT; i = i + 1) begin : g_out
            reg [19:0] ol_cnt_q;
            reg [19:0] oc_cnt_q;
            reg [19:0] rec_q;
            wire [1:0] map = pwm_map_q[2*i+1:2*i];
            wire gate = pwm_en_q[i] ? pwm_wave[map] : 1'b1;
            assign want_on[i] = out_on_q[i] & gate & ~oc_q[i] & ~tsd_q & ~clr_stat;
            assign ol_hit[i] = driving[i] && uc_s[i] && (ol_cnt_q == OL_FILT_CYC - 20'h00001);
            assign oc_hit[i] = driving[i] && ocr_s[i] && (oc_cnt_q == OC_FILT_CYC - 20'h00001);
            assign rec_done[i] = (rec_q == 20'h00001);
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    ol_cnt_q <= 20'h00000;
                    oc_cnt_q <= 20'h00000;
                    rec_q <= 20'h00000;
                end else begin
                    ol_cnt_q <= (driving[i] && uc_s[i] && !ol_hit[i]) ? ol_cnt_q + 20'h00001 : 20'h00000;
                    oc_cnt_q <= (driving[i] && ocr_s[i] && !oc_hit[i]) ? oc_cnt_q + 20'h00001 : 20'h00000;
                    if (clr_stat)
                        rec_q <= 20'h00000;
                    else if (oc_hit[i] && oc_rec_q[i])
                        rec_q <= rec_len;
                    else if (rec_q != 20'h00000)
                        rec_q <= rec_q - 20'h00001;
                end
            end
        end
    endgenerate

    wire sw_ol_clr = wr_en && (ofs == `OL_STAT_OFS);
    wire sw_oc_clr = wr_en && (ofs == `OC_STAT_OFS);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ol_q <= {NOUT{1'b0}};
            oc_q <= {NOUT{1'b0}};
        end else if (clr_stat) begin
            ol_q <= {NOUT{1'b0}};
            oc_q <= {NOUT{1'b0}};
        end else begin
            ol_q <= ol_hit | (ol_q & ~(sw_ol_clr ? pwdata[NOUT-1:0] : {NOUT{1'b0}}));
            // flag holds the driver off until software or recovery clears it
            oc_q <= oc_hit | (oc_q & ~(sw_oc_clr ? pwdata[NOUT-1:0] : {NOUT{1'b0}})
                & ~(rec_done & oc_rec_q));
        end
    end

    // half bridges with cross-conduction dead time
    wire [NOUT-1:0] hs_vec;
    genvar b;
    generate
        for (b = 0; b < NHB; b = b + 1) begin : g_hb
            reg hs_q;
            reg ls_q;
            reg fhs_q;
            reg fls_q;
            reg [19:0] dt_q;
            wire hs_want = want_on[b] & hb_side_q[b];
            wire ls_want = want_on[b] & ~hb_side_q[b];
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    hs_q <= 1'b0;
                    ls_q <= 1'b0;
                    fhs_q <= 1'b0;
                    fls_q <= 1'b0;
                    dt_q <= 20'h00000;
                end else if (hs_q && !hs_want) begin
                    hs_q <= 1'b0;
                    dt_q <= XC_CYC;
                end else if (ls_q && !ls_want) begin
                    ls_q <= 1'b0;
                    dt_q <= XC_CYC;
                end else if (dt_q != 20'h00000) begin
                    dt_q <= dt_q - 20'h00001;
                    if (dt_q == 20'h00001) begin
                        // slow off phase ends here, both fast-off flags set since neither side is on
                        fhs_q <= ~hs_q;
                        fls_q <= ~ls_q;
                    end
                end else if (hs_want && !ls_q) begin
                    hs_q <= 1'b1;
                    fhs_q <= 1'b0;
                end else if (ls_want && !hs_q) begin
                    ls_q <= 1'b1;
                    fls_q <= 1'b0;
                end
            end
            assign hs_vec[b] = hs_q;
            assign ls_drv[b] = ls_q;
            assign fast_off_hs[b] = fhs_q;
            assign fast_off_ls[b] = fls_q;
            assign driving[b] = hs_q | ls_q;
        end
        for (b = NHB; b < NOUT; b = b + 1) begin : g_hs
            reg on_q;
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n)
                    on_q <= 1'b0;
                else
                    on_q <= want_on[b];
            end
            assign hs_vec[b] = on_q;
            assign driving[b] = on_q;
        end
    endgenerate
    assign hs_drv = hs_vec;

    // current monitor routing with blanking
    reg [19:0] blank_q;
    reg [3:0] msel_d_q;
    wire sel_on = (msel_q < NOUT) ? hs_vec[msel_q] : 1'b0;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            blank_q <= BLANK_CYC;
            msel_d_q <= 4'h0;
            current_image_sel <= 4'h0;
            current_image_pin_oe <= 1'b0;
            drv_oe <= 1'b0;
            gate_rl <= 1'b1;
        end else begin
            msel_d_q <= msel_q;
            current_image_sel <= msel_q;
            // a select change restarts blanking, the new output may be mid-settle
            if (!sel_on || msel_q != msel_d_q)
                blank_q <= BLANK_CYC;
            else if (blank_q != 20'h00000)
                blank_q <= blank_q - 20'h00001;
            current_image_pin_oe <= sel_on && (blank_q == 20'h00000) && !vcc_low_s;
            drv_oe <= ~vcc_low_s;
            gate_rl <= tsd_q | clr_all;
        end
    end

    // apb read data, captured in the setup cycle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= ~mapped;
            prdata <= 32'h00000000;
            case (ofs)
                `OUT_ON_OFS: prdata[NOUT-1:0] <= out_on_q;
                `HB_SIDE_OFS: prdata[NHB-1:0] <= hb_side_q;
                `PWM_EN_OFS: prdata[NOUT-1:0] <= pwm_en_q;
                `OC_REC_OFS: prdata[NOUT-1:0] <= oc_rec_q;
                `CFG_OFS: prdata[7:0] <= {msel_q, 2'b00, rduty_q, freq_q};
                `DUTY_OFS: prdata <= {1'b0, duty_q[27:21], 1'b0, duty_q[20:14], 1'b0, duty_q[13:7], 1'b0, duty_q[6:0]};
                `PWM_MAP_OFS: prdata[2*NOUT-1:0] <= pwm_map_q;
                `GSTAT_OFS: prdata[2:0] <= {vcc_low_s, tsd_q, warn_q};
                `OL_STAT_OFS: prdata[NOUT-1:0] <= ol_q;
                `OC_STAT_OFS: prdata[NOUT-1:0] <= oc_q;
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// file: src/sync2.v
`timescale 1ns/100ps
module sync2 #(
    parameter WIDTH = 1
) (
    input wire mclk,
    input wire rst_n,
    input wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule
